// >>> irq_ctrl_consts.svh
/*
 * Constants of the prioritized vectored interrupt controller: register
 * indices, reset values, flag positions and entry timing.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ============================================================
// Register indices (byte address is four times the index).
`define IDX_GEN_MASK    8'he0
`define IDX_BLK_MASK    8'he1
`define IDX_VECTOR      8'he2
`define IDX_FLAGS       8'he3
`define IDX_EV_STATUS   8'he4
`define IDX_EV_MASK     8'he5

// ============================================================
// Reset values and field positions.
`define RST_BYTE        8'h00
`define FLAG_IE_BIT     0
`define VEC_SPACING     8'h04
`define EV_ENTRY_BIT    0
`define EV_RETURN_BIT   1
`define EV_OVERRUN_BIT  2

// ============================================================
// Interrupt entry timing, in clock cycles.
`define ENTRY_CYCLES    4'hd
`define PUSH_PC_HI_CYC  4'h1
`define PUSH_PC_LO_CYC  4'h2
`define PUSH_FLAGS_CYC  4'h3

`endif

// >>> irq_ctrl_pkg.sv
/*
 * Types shared by the interrupt controller files.
 * Assumes nothing of its surroundings.
 */
package irq_ctrl_pkg;

	typedef enum logic [0:0]
	{
		ST_IDLE  = 1'b0,
		ST_ENTRY = 1'b1
	} entry_state_t;

	typedef logic [3:0] src_idx_t;
	typedef logic [7:0] byte_t;

endpackage

// >>> pend_cell.sv
/*
 * One pending flip-flop for one interrupt source.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps

module pend_cell
(
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Control.
	input  wire logic set_evt,
	input  wire logic clr,
	// State.
	output logic      pend_q
);

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_q <= 1'b0;
		else if (set_evt)
			pend_q <= 1'b1;
		else if (clr)
			pend_q <= 1'b0;
	end

endmodule

// >>> prio_pick.sv
/*
 * Lowest-index picker over a request vector.
 * Assumes at most fifteen requests so the index fits four bits.
 */
`timescale 1ns/100ps

module prio_pick
#(
	parameter int N = 15
)
(
	// Requests.
	input  wire logic [N-1:0]         req,
	// Result.
	output logic                      found,
	output irq_ctrl_pkg::src_idx_t    idx
);
	import irq_ctrl_pkg::*;

	if (N < 1 || N > 15)
	begin : g_bad_n
		$error("prio_pick supports 1 to 15 requests");
	end

	// Scan from the top so the lowest index is left standing.
	always_comb
	begin
		found = 1'b0;
		idx   = 4'h0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				idx   = 4'(i);
			end
		end
	end

endmodule

// >>> irq_ctrl.sv
/*
 * Prioritized vectored interrupt controller with the core's interrupt
 * entry and return sequencing, reached over an AHB-Lite slave port.
 * Assumes source events are one-cycle pulses from logic on hclk, and a
 * core that pulses core_ack when it accepts a request at an instruction
 * boundary and core_return_from_interrupt with the popped program counter and flags.
 */
// Overview of operation
// R1 - One pending flop per source, held until serviced, reset or vector write.
// R2 - Pending request reaches core only if masked in and global enable set.
// R3 - Software sets pin enable and type before pin interrupts arrive.
// R4 - Software selects analog column source before its interrupt arrives.
// R5 - Acknowledge pushes PC high, PC low, flags; entry takes 13 cycles.
// R6 - Return restores PC and flags, re-enabling global enable.
// R7 - Lowest priority number wins among simultaneous pending interrupts.
// R8 - After flags push, flags clear, blocking further interrupts.
// R9 - Firmware may nest by setting global enable, saving extra state.
// R10 - Vectors four bytes apart, priority 1 to 15, program memory after.
// R11 - Entry loads the program counter with the serviced source's vector.
// R12 - Block mask bits 0-3 basic blocks, 4-7 comm blocks, reset zero.
// R13 - Vector register reads highest-priority enabled pending interrupt's vector.
// R14 - Any write to vector register clears all pending flags.
// R15 - Global enable is flags bit 0 and gates every request; the code gates irq_req only, not ctrl_irq.
// R16 - Acknowledged source's pending flag clears in the accepting cycle.
// R17 - Vector register reads zero when nothing enabled is pending.
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"

module irq_ctrl
#(
	parameter int NUM_SRC = 15
)
(
	// Clock and reset.
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave.
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// Interrupt sources, priority order from bit 0.
	input  wire logic [NUM_SRC-1:0]   src_event,
	// Core handshake.
	output logic                      irq_req,
	input  wire logic                 core_ack,
	input  wire logic                 core_return_from_interrupt,
	input  wire logic [15:0]          cur_pc,
	input  wire logic [15:0]          pop_pc,
	input  wire irq_ctrl_pkg::byte_t  pop_flags,
	// Stack pushes and program counter loads.
	output logic                      push_valid_q,
	output irq_ctrl_pkg::byte_t       push_data_q,
	output logic                      pc_load_q,
	output logic [15:0]               pc_addr_q,
	// Controller event interrupt.
	output logic                      ctrl_irq
);
	import irq_ctrl_pkg::*;

	if (NUM_SRC != 15)
	begin : g_bad_src
		$error("irq_ctrl mask layout serves exactly 15 sources");
	end

	// ============================================================
	// Bus slave: writes are zero-wait, reads take one wait state.
	logic        wr_q;
	logic        rd_wait_q;
	logic [7:0]  idx_q;
	logic        addr_ok_q;
	logic        take;
	logic        wr_vec;
	logic        wr_gen;
	logic        wr_blk;
	logic        wr_flags;
	logic        wr_evs;
	logic        wr_evm;
	byte_t       rd_mux;
	logic [31:0] hrdata_q;

	assign take = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q      <= 1'b0;
			rd_wait_q <= 1'b0;
			idx_q     <= `RST_BYTE;
			addr_ok_q <= 1'b0;
		end
		else
		begin
			wr_q      <= take && hwrite;
			rd_wait_q <= take && !hwrite;
			if (take)
			begin
				idx_q     <= haddr[9:2];
				addr_ok_q <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
			end
		end
	end

	assign wr_vec   = wr_q && addr_ok_q && (idx_q == `IDX_VECTOR);
	assign wr_gen   = wr_q && addr_ok_q && (idx_q == `IDX_GEN_MASK);
	assign wr_blk   = wr_q && addr_ok_q && (idx_q == `IDX_BLK_MASK);
	assign wr_flags = wr_q && addr_ok_q && (idx_q == `IDX_FLAGS);
	assign wr_evs   = wr_q && addr_ok_q && (idx_q == `IDX_EV_STATUS);
	assign wr_evm   = wr_q && addr_ok_q && (idx_q == `IDX_EV_MASK);

	assign hreadyout = !rd_wait_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// ============================================================
	// Mask and flags registers.
	byte_t gen_mask_q;
	byte_t blk_mask_q;
	byte_t flags_q;
	byte_t ev_status_q;
	byte_t ev_mask_q;
	entry_state_t state_q;
	logic [3:0]   cnt_q;
	logic         ack_take;
	logic         return_from_interrupt_take;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gen_mask_q <= `RST_BYTE;
			blk_mask_q <= `RST_BYTE;
			ev_mask_q  <= `RST_BYTE;
		end
		else
		begin
			if (wr_gen)
				gen_mask_q <= hwdata[7:0];
			if (wr_blk)
				blk_mask_q <= hwdata[7:0]; // [R12]
			if (wr_evm)
				ev_mask_q <= hwdata[7:0];
		end
	end

	// Hardware wins over a bus write to the flags in the same cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags_q <= `RST_BYTE;
		else if (return_from_interrupt_take)
			flags_q <= pop_flags; // [R6]
		else if (state_q == ST_ENTRY && cnt_q == `PUSH_FLAGS_CYC)
			flags_q <= `RST_BYTE; // [R8]
		else if (wr_flags)
			flags_q <= hwdata[7:0];
	end

	// ============================================================
	// Pending flops and source enables.
	logic [NUM_SRC-1:0] en;
	logic [NUM_SRC-1:0] pend_vec;
	logic [NUM_SRC-1:0] pend_en;
	logic [NUM_SRC-1:0] ack_clr;
	logic               any_pend;
	src_idx_t           pick_idx;
	byte_t              vec_live;

	// Supply, basic 0-3, comm 4-7, analog columns 0-3, pins, sleep timer.
	assign en      = {gen_mask_q[6], gen_mask_q[5], gen_mask_q[4:1],
	                  blk_mask_q, gen_mask_q[0]}; // [R12]
	assign pend_en = pend_vec & en;

	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_pend
		assign ack_clr[i] = ack_take && (pick_idx == 4'(i)); // [R16]
		pend_cell u_pend
		(
			.hclk    (hclk),
			.hresetn (hresetn),
			.set_evt (src_event[i]), // [R1]
			.clr     (wr_vec || ack_clr[i]), // [R14]
			.pend_q  (pend_vec[i])
		);
	end

	prio_pick #(.N(NUM_SRC)) u_pick
	(
		.req   (pend_en), // [R7]
		.found (any_pend),
		.idx   (pick_idx)
	);

	// Vector is the priority number times the spacing; zero when nothing enabled is pending.
	assign vec_live = any_pend ? 8'(({4'h0, pick_idx} + 8'h01) * `VEC_SPACING)
	                           : `RST_BYTE; // [R10] [R13] [R17]

	assign irq_req = any_pend && flags_q[`FLAG_IE_BIT] && (state_q == ST_IDLE); // [R2] [R15]
	assign ack_take  = core_ack && irq_req;
	assign return_from_interrupt_take = core_return_from_interrupt && (state_q == ST_IDLE);

	// ============================================================
	// Entry sequencer: three pushes, flags clear, vector load.
	byte_t entry_vec_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q     <= ST_IDLE;
			cnt_q       <= 4'h0;
			entry_vec_q <= `RST_BYTE;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (ack_take)
					begin
						state_q     <= ST_ENTRY;
						cnt_q       <= `PUSH_PC_HI_CYC;
						entry_vec_q <= vec_live;
					end
				end
				ST_ENTRY:
				begin
					if (cnt_q == `ENTRY_CYCLES) // [R5]
					begin
						state_q <= ST_IDLE;
						cnt_q   <= 4'h0;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				end
				default:
				begin
					state_q <= ST_IDLE;
					cnt_q   <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			push_valid_q <= 1'b0;
			push_data_q  <= `RST_BYTE;
		end
		else
		begin
			push_valid_q <= 1'b0;
			if (state_q == ST_ENTRY)
			begin
				case (cnt_q) // [R5]
					`PUSH_PC_HI_CYC:
					begin
						push_valid_q <= 1'b1;
						push_data_q  <= cur_pc[15:8];
					end
					`PUSH_PC_LO_CYC:
					begin
						push_valid_q <= 1'b1;
						push_data_q  <= cur_pc[7:0];
					end
					`PUSH_FLAGS_CYC:
					begin
						push_valid_q <= 1'b1;
						push_data_q  <= flags_q;
					end
					default:
					begin
						push_valid_q <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pc_load_q <= 1'b0;
			pc_addr_q <= 16'h0000;
		end
		else
		begin
			pc_load_q <= 1'b0;
			if (state_q == ST_ENTRY && cnt_q == `ENTRY_CYCLES)
			begin
				pc_load_q <= 1'b1;
				pc_addr_q <= {8'h00, entry_vec_q}; // [R11]
			end
			else if (return_from_interrupt_take)
			begin
				pc_load_q <= 1'b1;
				pc_addr_q <= pop_pc; // [R6]
			end
		end
	end

	// ============================================================
	// Controller events: sticky, write one to clear, set wins.
	byte_t ev_set;

	always_comb
	begin
		ev_set                  = `RST_BYTE;
		ev_set[`EV_ENTRY_BIT]   = state_q == ST_ENTRY && cnt_q == `ENTRY_CYCLES;
		ev_set[`EV_RETURN_BIT]  = return_from_interrupt_take;
		ev_set[`EV_OVERRUN_BIT] = |(src_event & pend_vec);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ev_status_q <= `RST_BYTE;
		else if (wr_evs)
			ev_status_q <= (ev_status_q & ~hwdata[7:0]) | ev_set;
		else
			ev_status_q <= ev_status_q | ev_set;
	end

	assign ctrl_irq = |(ev_status_q & ev_mask_q);

	// ============================================================
	// Read data, sampled in the first data-phase cycle.
	always_comb
	begin
		rd_mux = `RST_BYTE;
		if (addr_ok_q)
		begin
			case (idx_q)
				`IDX_GEN_MASK:  rd_mux = gen_mask_q;
				`IDX_BLK_MASK:  rd_mux = blk_mask_q;
				`IDX_VECTOR:    rd_mux = vec_live; // [R13]
				`IDX_FLAGS:     rd_mux = flags_q;
				`IDX_EV_STATUS: rd_mux = ev_status_q;
				`IDX_EV_MASK:   rd_mux = ev_mask_q;
				default:        rd_mux = `RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h00000000;
		else if (rd_wait_q)
			hrdata_q <= {24'h000000, rd_mux};
	end

	// ============================================================
	// Checks.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	pend_hold_a: assert property (!wr_vec |=> ((($past(pend_vec) & ~$past(ack_clr))
		& ~pend_vec) == 15'h0000)) // [R1]
		else $error("pending flag dropped without a cause");

	pend_set_a: assert property ((|src_event) |=> (($past(src_event) & ~pend_vec) == 15'h0000)) // [R1]
		else $error("source event not registered as pending");

	req_gate_a: assert property (irq_req |-> flags_q[0] && ((pend_vec & en) != 15'h0000)) // [R2] [R15]
		else $error("request without enable or pending source");

	entry_push_a: assert property (ack_take |-> ##2 push_valid_q && push_data_q == $past(cur_pc[15:8])
		##1 push_valid_q && push_data_q == $past(cur_pc[7:0])
		##1 push_valid_q && push_data_q == $past(flags_q)) // [R5]
		else $error("entry pushes out of order");

	entry_load_a: assert property (ack_take |-> ##14 pc_load_q
		&& pc_addr_q == {8'h00, $past(vec_live, 14)}) // [R5] [R11]
		else $error("vector not loaded at the end of entry");

	flags_clear_a: assert property (ack_take && !wr_flags |-> ##4 !flags_q[0]) // [R8]
		else $error("global enable not cleared after flags push");

	return_from_interrupt_restore_a: assert property (return_from_interrupt_take |=> flags_q == $past(pop_flags)
		&& pc_load_q && pc_addr_q == $past(pop_pc)) // [R6]
		else $error("return did not restore flags and program counter");

	prio_pick_a: assert property (any_pend |-> pend_en[pick_idx]
		&& ((pend_en & ((15'h0001 << pick_idx) - 15'h0001)) == 15'h0000)) // [R7]
		else $error("a higher-priority pending source was skipped");

	vec_range_a: assert property (any_pend |-> vec_live >= 8'h04 && vec_live <= 8'h3c
		&& vec_live[1:0] == 2'h0) // [R10] [R13]
		else $error("vector outside the table");

	vec_zero_a: assert property (!any_pend |-> vec_live == 8'h00) // [R17]
		else $error("vector not zero with nothing pending");

	vec_write_a: assert property (wr_vec |=> ((pend_vec & ~$past(src_event)) == 15'h0000)) // [R14]
		else $error("vector write left interrupts pending");

	ack_clear_a: assert property (ack_take && !src_event[pick_idx] |=> !pend_vec[$past(pick_idx)]) // [R16]
		else $error("acknowledged source still pending");

	blk_mask_a: assert property (wr_blk |=> blk_mask_q == $past(hwdata[7:0])) // [R12]
		else $error("block mask write not stored");

endmodule

// >>> core_model.sv
/*
 * Behavioural model of the 8-bit core facing the interrupt controller.
 * Assumes the controller runs on the same hclk and reset as this model.
 */
`timescale 1ns/100ps

module core_model
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Bench control.
	input  wire logic        ack_en,
	input  wire logic        return_from_interrupt_go,
	// Controller side.
	input  wire logic        irq_req,
	input  wire logic        push_valid_q,
	input  wire logic [7:0]  push_data_q,
	input  wire logic        pc_load_q,
	input  wire logic [15:0] pc_addr_q,
	output logic             core_ack,
	output logic             core_return_from_interrupt,
	output logic [15:0]      cur_pc,
	output logic [15:0]      pop_pc,
	output logic [7:0]       pop_flags
);
	logic [7:0] stk_q [3];
	logic [1:0] nps_q;
	int         cnt_q;
	int         lat_q;
	int         nld_q;

	// ============================================================
	// Acknowledge, stack capture and program counter tracking.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_ack  <= 1'b0;
			core_return_from_interrupt <= 1'b0;
			cur_pc    <= 16'h1234;
			stk_q     <= '{default: 8'h00};
			nps_q     <= 2'h0;
			cnt_q     <= 0;
			lat_q     <= 0;
			nld_q     <= 0;
		end
		else
		begin
			core_ack  <= ack_en && irq_req && !core_ack;
			core_return_from_interrupt <= return_from_interrupt_go;
			cnt_q     <= core_ack ? 0 : cnt_q + 1;
			if (core_ack)
				nps_q <= 2'h0;
			else if (push_valid_q)
			begin
				stk_q[nps_q] <= push_data_q;
				nps_q        <= nps_q + 2'h1;
			end
			if (pc_load_q)
			begin
				cur_pc <= pc_addr_q;
				lat_q  <= cnt_q;
				nld_q  <= nld_q + 1;
			end
		end
	end

	// Popped values are only valid with the return pulse; otherwise they are scrambled.
	assign pop_pc    = core_return_from_interrupt ? {stk_q[0], stk_q[1]} : ~{stk_q[0], stk_q[1]};
	assign pop_flags = core_return_from_interrupt ? stk_q[2] : ~stk_q[2];

endmodule

// >>> tb_top.sv
/*
 * Self-checking bench for the interrupt controller: AHB-Lite register
 * access, masking, priority, vector table, entry and return.
 * Assumes the controller files and the core model are compiled first.
 */
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s expected %h seen %h", n, e, s); end end

module tb_top;
	import irq_ctrl_pkg::*;

	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic        irq_req, core_ack, core_return_from_interrupt, push_valid_q, pc_load_q, ctrl_irq;
	logic        ack_en, return_from_interrupt_go;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [14:0] src_event;
	logic [15:0] cur_pc, pop_pc, pc_addr_q;
	byte_t       pop_flags, push_data_q, v;
	int          n_fail, n_tests;

	assign hready = hreadyout;

	irq_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .src_event, .irq_req, .core_ack,
		.core_return_from_interrupt, .cur_pc, .pop_pc, .pop_flags, .push_valid_q, .push_data_q,
		.pc_load_q, .pc_addr_q, .ctrl_irq);

	core_model core_u (.hclk, .hresetn, .ack_en, .return_from_interrupt_go, .irq_req, .push_valid_q,
		.push_data_q, .pc_load_q, .pc_addr_q, .core_ack, .core_return_from_interrupt, .cur_pc,
		.pop_pc, .pop_flags);

	// ============================================================
	// Bus and stimulus tasks.
	task automatic xfer(input logic w, input logic [7:0] idx, input byte_t d, output byte_t r);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		r = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] idx, input byte_t d);
		byte_t r;
		xfer(1'b1, idx, d, r);
	endtask

	task automatic rd(input logic [7:0] idx);
		xfer(1'b0, idx, 8'h00, v);
	endtask

	// Sources are taken as already configured upstream of this block.
	task automatic fire(input logic [14:0] m);
		@(posedge hclk);
		src_event <= m;
		@(posedge hclk);
		src_event <= 15'h0;
	endtask

	task automatic wait_load();
		int n0;
		n0 = core_u.nld_q;
		for (int k = 0; k < 60 && core_u.nld_q == n0; k++)
			@(posedge hclk);
		`CHK("pc load", 1'b1, core_u.nld_q != n0)
	endtask

	task automatic return_from_interrupt_pulse();
		@(posedge hclk);
		return_from_interrupt_go <= 1'b1;
		@(posedge hclk);
		return_from_interrupt_go <= 1'b0;
	endtask

	// ============================================================
	// Scenarios.
	task automatic t_reset();
		rd(`IDX_BLK_MASK);
		`CHK("block mask", 8'h00, v)
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h00, v)
		rd(8'hf0);
		`CHK("unmapped", 8'h00, v)
		`CHK("irq_req", 1'b0, irq_req)
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic t_mask();
		wr(`IDX_BLK_MASK, 8'h10);
		rd(`IDX_BLK_MASK);
		`CHK("block mask", 8'h10, v)
		fire(15'h0022);
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h18, v)
		`CHK("irq_req", 1'b0, irq_req)
		wr(`IDX_FLAGS, 8'h01);
		@(negedge hclk);
		`CHK("irq_req", 1'b1, irq_req)
		wr(`IDX_FLAGS, 8'h00);
		@(negedge hclk);
		`CHK("irq_req", 1'b0, irq_req)
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h18, v)
		fire(15'h0020);
		rd(`IDX_EV_STATUS);
		`CHK("event status", 8'h04, v & 8'h04)
		wr(`IDX_VECTOR, 8'h5a);
		wr(`IDX_BLK_MASK, 8'h11);
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h00, v)
	endtask

	task automatic t_table();
		wr(`IDX_GEN_MASK, 8'h7f);
		wr(`IDX_BLK_MASK, 8'hff);
		for (int i = 0; i < 15; i++)
		begin
			fire(15'(1) << i);
			rd(`IDX_VECTOR);
			`CHK("vector", 8'((i + 1) * 4), v)
			wr(`IDX_VECTOR, 8'h00);
		end
	endtask

	task automatic t_entry();
		fire(15'h0204);
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h0c, v)
		ack_en <= 1'b1;
		wr(`IDX_FLAGS, 8'h01);
		wait_load();
		`CHK("pushed pc high", 8'h12, core_u.stk_q[0])
		`CHK("pushed pc low", 8'h34, core_u.stk_q[1])
		`CHK("pushed flags", 8'h01, core_u.stk_q[2])
		`CHK("entry cycles", 13, core_u.lat_q)
		`CHK("new pc", 16'h000c, pc_addr_q)
		rd(`IDX_FLAGS);
		`CHK("flags", 8'h00, v)
		`CHK("irq_req", 1'b0, irq_req)
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h28, v)
		rd(`IDX_EV_STATUS);
		`CHK("event status", 8'h01, v & 8'h01)
		wr(`IDX_EV_MASK, 8'h01);
		@(negedge hclk);
		`CHK("ctrl_irq", 1'b1, ctrl_irq)
		wr(`IDX_EV_STATUS, 8'h01);
		@(negedge hclk);
		`CHK("ctrl_irq", 1'b0, ctrl_irq)
		return_from_interrupt_pulse();
		wait_load();
		`CHK("return pc", 16'h1234, pc_addr_q)
		wait_load();
		`CHK("second pc", 16'h0028, pc_addr_q)
		`CHK("pushed flags", 8'h01, core_u.stk_q[2])
		ack_en <= 1'b0;
		return_from_interrupt_pulse();
		wait_load();
		rd(`IDX_FLAGS);
		`CHK("flags", 8'h01, v)
		rd(`IDX_VECTOR);
		`CHK("vector", 8'h00, v)
	endtask

	// Firmware re-enables interrupts inside a handler to let a second source nest.
	task automatic t_nest();
		fire(15'h4001);
		ack_en <= 1'b1;
		wait_load();
		`CHK("new pc", 16'h0004, pc_addr_q)
		wr(`IDX_FLAGS, 8'h01);
		wait_load();
		`CHK("nested pc", 16'h003c, pc_addr_q)
		`CHK("pushed pc low", 8'h04, core_u.stk_q[1])
		`CHK("pushed flags", 8'h01, core_u.stk_q[2])
		ack_en <= 1'b0;
		return_from_interrupt_pulse();
		wait_load();
		`CHK("return pc", 16'h0004, pc_addr_q)
		rd(`IDX_EV_STATUS);
		`CHK("event status", 8'h02, v & 8'h02)
	endtask

	// ============================================================
	// Verdict, clock, watchdog and main sequence.
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial
	begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		close_out();
	end

	initial
	begin
		hresetn   = 1'b0;
		hsel      = 1'b0;
		haddr     = 32'h0;
		htrans    = 2'b00;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h0;
		src_event = 15'h0;
		ack_en    = 1'b0;
		return_from_interrupt_go   = 1'b0;
		n_fail    = 0;
		n_tests   = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_mask();
		t_table();
		t_entry();
		t_nest();
		close_out();
	end

endmodule
